/* inc/fdc_rate_pkg.sv */
// Constants, types and delay tables shared by the floppy status and rate registers.
package fdc_rate_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_STATUS_RATE = 8'h04; // Read: status, write: rate
    localparam logic [ADDR_W-1:0] ADDR_ALT_RATE = 8'h08;    // Alternate rate control
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h0C;      // Tape rate and mode config

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Rate register field positions
    localparam int RATE_SWRST_BIT = 7;
    localparam int RATE_PWRDN_BIT = 6;
    localparam int COMP_HI = 4;
    localparam int COMP_LO = 2;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;

    // Rate register reset value and its fields
    localparam logic [7:0] RATE_RESET = 8'h02;
    localparam logic PWRDN_RESET = RATE_RESET[RATE_PWRDN_BIT];
    localparam logic [2:0] COMP_RESET = RATE_RESET[COMP_HI:COMP_LO];
    localparam logic [1:0] SEL_RESET = RATE_RESET[SEL_HI:SEL_LO];

    // Status byte field positions
    localparam int ST_REQUEST = 7;
    localparam int ST_DIRECTION = 6;
    localparam int ST_NONDMA = 5;
    localparam int ST_BUSY = 4;
    localparam int ST_SEEK_HI = 3;
    localparam int ST_SEEK_LO = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Config register field positions and reset values
    localparam int CFG_TAPE_HI = 1;
    localparam int CFG_TAPE_LO = 0;
    localparam int CFG_PCMODE = 2;
    localparam logic [1:0] TAPE_CFG_RESET = 2'h0;
    localparam logic PCMODE_RESET = 1'b0;

    // Rate selection codes
    localparam logic [1:0] SEL_500 = 2'h0;
    localparam logic [1:0] SEL_300 = 2'h1;
    localparam logic [1:0] SEL_250 = 2'h2;
    localparam logic [1:0] SEL_1M = 2'h3;
    localparam logic [1:0] TAPE_CFG_2M = 2'h2;
    localparam logic [2:0] COMP_DEFAULT = 3'h0;

    // Effective rate presented to the data path
    typedef enum logic [2:0] {
        RATE_500 = 3'b000,
        RATE_300 = 3'b001,
        RATE_250 = 3'b010,
        RATE_1M = 3'b011,
        RATE_2M = 3'b100
    } rate_t;

    // Software reset pulse length
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int SW_RESET_NS = 16;
    localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [2:0] SW_RESET_LOAD = 3'(SW_RESET_CYCLES);

    // Precompensation delays in picoseconds
    typedef logic [17:0] delay_ps_t;
    localparam delay_ps_t DELAY_OFF = 18'h00000;
    localparam delay_ps_t DELAY_125NS = 18'h1E848;
    localparam delay_ps_t DELAY_41NS = 18'h0A2C6;
    localparam delay_ps_t DELAY_21NS = 18'h05140;
    // Disk rates: 41.67 ns steps up to 250 ns, last code disables
    localparam delay_ps_t COMP_DISK_PS [8] = '{18'h00000, 18'h0A2C6, 18'h1458C, 18'h1E848,
                                               18'h28B0E, 18'h32DCA, 18'h3D090, 18'h00000};
    // Tape rate: halved steps starting at 20.8 ns
    localparam delay_ps_t COMP_TAPE_PS [8] = '{18'h00000, 18'h05140, 18'h0A0D2, 18'h0F424,
                                               18'h14564, 18'h19708, 18'h1E848, 18'h00000};

endpackage

/* src/fdc_status_rate_regs.sv */
// Main status and data rate registers of the floppy controller behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module fdc_status_rate_regs
    import fdc_rate_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data channel
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data channel
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Controller core state shown in the status byte
    input wire logic dataRegReady,
    input wire logic toHost,
    input wire logic execNonDma,
    input wire logic cmdBusy,
    input wire logic [3:0] driveSeeking,
    // Controls to the rest of the controller
    output logic softReset,
    output logic powerDown,
    output rate_t rateCode,
    output logic lowWriteCurrentN,
    output delay_ps_t writeCompPs
);

    // ------------------------------------------------------------
    // Write channel state
    // ------------------------------------------------------------
    logic awHeld; // Address taken, waiting for data
    logic wHeld; // Data taken, waiting for address
    logic [ADDR_W-1:0] awAddrQ; // Held write address
    logic [DATA_W-1:0] wDataQ; // Held write data
    logic [STRB_W-1:0] wStrbQ; // Held byte strobes

    logic awTake; // Address handshake this cycle
    logic wTake; // Data handshake this cycle
    logic addrReady; // Address present now or held
    logic dataReady; // Data present now or held
    logic wrDo; // Register write happens this cycle
    logic [ADDR_W-1:0] wrAddr; // Address used by the write
    logic [DATA_W-1:0] wrData; // Data used by the write
    logic [STRB_W-1:0] wrStrb; // Strobes used by the write
    logic wrMapped; // Write address decodes
    logic next_awHeld;
    logic next_wHeld;
    logic next_bvalid;
    logic next_awready;
    logic next_wready;

    // ------------------------------------------------------------
    // Read channel state
    // ------------------------------------------------------------
    logic arTake; // Read address handshake
    logic next_rvalid;
    logic next_arready;
    logic rdMapped; // Read address decodes
    logic [DATA_W-1:0] rdMux; // Data for the read address

    // ------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------
    logic [7:0] statusByte; // Sampled main status byte
    logic [7:0] next_statusByte;
    logic [2:0] compSel; // Precompensation selection
    logic [1:0] rateSel; // Data rate selection
    logic [1:0] altRate; // Alternate rate control
    logic [1:0] tapeCfg; // Tape rate configuration
    logic pcMode; // PC compatible mode select
    logic [2:0] swCount; // Software reset cycles left
    logic [2:0] next_swCount;

    // Decoded write strobes
    logic rateWrite; // Write to the rate register
    logic altWrite; // Write to the alternate rate
    logic cfgWrite; // Write to the config register
    logic swStart; // Software reset requested

    // Status fields named for what they show
    logic hostTransferRequest;
    logic transferDirection;
    logic controllerBusy;
    logic drive3Seeking;
    logic drive2Seeking;
    logic drive1Seeking;
    logic drive0Seeking;

    // Address compare used by both channels
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        isMapped = (addr == ADDR_STATUS_RATE) || (addr == ADDR_ALT_RATE) || (addr == ADDR_CONFIG);
    endfunction

    // ------------------------------------------------------------
    // Write path decode
    // ------------------------------------------------------------
    assign awTake = awvalid && awready;
    assign wTake = wvalid && wready;
    assign addrReady = awHeld || awTake;
    assign dataReady = wHeld || wTake;
    // Write fires once both halves are in, either order
    assign wrDo = addrReady && dataReady;
    assign wrAddr = awHeld ? awAddrQ : awaddr;
    assign wrData = wHeld ? wDataQ : wdata;
    assign wrStrb = wHeld ? wStrbQ : wstrb;
    assign wrMapped = isMapped(wrAddr);
    assign next_awHeld = addrReady && !wrDo;
    assign next_wHeld = dataReady && !wrDo;
    assign next_bvalid = wrDo || (bvalid && !bready);
    // One write under way: no new halves while a response waits
    assign next_awready = !next_awHeld && !next_bvalid;
    assign next_wready = !next_wHeld && !next_bvalid;

    // Register writes need the low byte lane
    assign rateWrite = wrDo && wrStrb[0] && (wrAddr == ADDR_STATUS_RATE);
    assign altWrite = wrDo && wrStrb[0] && (wrAddr == ADDR_ALT_RATE);
    assign cfgWrite = wrDo && wrStrb[0] && (wrAddr == ADDR_CONFIG);
    assign swStart = rateWrite && wrData[RATE_SWRST_BIT];

    // ------------------------------------------------------------
    // Read path decode
    // ------------------------------------------------------------
    assign arTake = arvalid && arready;
    assign next_rvalid = arTake || (rvalid && !rready);
    assign next_arready = !next_rvalid;
    assign rdMapped = isMapped(araddr);
    // Unused upper bits read as zero
    assign rdMux = (araddr == ADDR_STATUS_RATE) ? {24'h000000, statusByte} :
                   (araddr == ADDR_ALT_RATE) ? {30'h00000000, altRate} :
                   (araddr == ADDR_CONFIG) ? {29'h00000000, pcMode, tapeCfg} : 32'h00000000;

    // ------------------------------------------------------------
    // Status byte assembly
    // ------------------------------------------------------------
    assign hostTransferRequest = dataRegReady;
    assign transferDirection = toHost;
    assign controllerBusy = cmdBusy;
    assign drive3Seeking = driveSeeking[3];
    assign drive2Seeking = driveSeeking[2];
    assign drive1Seeking = driveSeeking[1];
    assign drive0Seeking = driveSeeking[0];
    assign next_statusByte = {hostTransferRequest, transferDirection, execNonDma, controllerBusy,
                              drive3Seeking, drive2Seeking, drive1Seeking, drive0Seeking};

    // Software reset counter next value
    assign next_swCount = swStart ? SW_RESET_LOAD :
                          (swCount != 3'h0) ? swCount - 3'h1 : 3'h0;

    // ------------------------------------------------------------
    // Write channel handshake registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
        end
    end

    // Capture write halves and response code
    always_ff @(posedge clock) begin
        if (!resetn) begin
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
            bresp <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddrQ <= awaddr;
            end
            if (wTake) begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (wrDo) begin
                bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            arready <= next_arready;
            rvalid <= next_rvalid;
            if (arTake) begin
                rdata <= rdMux;
                rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Status byte sampled every cycle, cleared by reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            statusByte <= STATUS_RESET;
        end else begin
            statusByte <= next_statusByte;
        end
    end

    // Rate register fields; bit 5 is not stored
    always_ff @(posedge clock) begin
        if (!resetn) begin
            powerDown <= PWRDN_RESET;
            compSel <= COMP_RESET;
            rateSel <= SEL_RESET;
        end else if (rateWrite) begin
            powerDown <= wrData[RATE_PWRDN_BIT];
            compSel <= wrData[COMP_HI:COMP_LO];
            rateSel <= wrData[SEL_HI:SEL_LO];
        end
    end

    // Alternate rate and config registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            altRate <= SEL_RESET;
            tapeCfg <= TAPE_CFG_RESET;
            pcMode <= PCMODE_RESET;
        end else begin
            if (altWrite) begin
                altRate <= wrData[SEL_HI:SEL_LO];
            end
            if (cfgWrite) begin
                tapeCfg <= wrData[CFG_TAPE_HI:CFG_TAPE_LO];
                pcMode <= wrData[CFG_PCMODE];
            end
        end
    end

    // Software reset pulse of fixed length
    always_ff @(posedge clock) begin
        if (!resetn) begin
            swCount <= 3'h0;
            softReset <= 1'b0;
        end else begin
            swCount <= next_swCount;
            softReset <= (next_swCount != 3'h0);
        end
    end

    // Rate source choice and write current
    rate_select rateSelect (
        .clock(clock),
        .resetn(resetn),
        .rateSel(rateSel),
        .altRate(altRate),
        .rateWrite(rateWrite),
        .altWrite(altWrite),
        .pcMode(pcMode),
        .tapeCfg(tapeCfg),
        .rateCode(rateCode),
        .lowWriteCurrentN(lowWriteCurrentN)
    );

    // Precompensation delay lookup
    precomp_delay precompDelay (
        .clock(clock),
        .resetn(resetn),
        .compSel(compSel),
        .rateCode(rateCode),
        .delayPs(writeCompPs)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence rateWriteSeq;
        rateWrite && !wrData[RATE_SWRST_BIT];
    endsequence

    sequence swPulseSeq;
        softReset [*4];
    endsequence

    chk_request_reset: assert property (@(posedge clock)
        !resetn |=> statusByte[ST_REQUEST] == 1'b0)
        else $error("request flag set right after reset");

    chk_status_read: assert property (@(posedge clock) disable iff (!resetn)
        arTake && araddr == ADDR_STATUS_RATE |=> rvalid && rdata[7:0] == $past(statusByte))
        else $error("status read returned wrong byte");

    chk_request_track: assert property (@(posedge clock) disable iff (!resetn)
        $past(resetn) && !$past(dataRegReady) |-> !statusByte[ST_REQUEST])
        else $error("request flag high while data register not ready");

    chk_direction_bit: assert property (@(posedge clock) disable iff (!resetn)
        $past(resetn) |-> statusByte[ST_DIRECTION] == $past(toHost))
        else $error("direction bit wrong");

    chk_nondma_clear: assert property (@(posedge clock) disable iff (!resetn)
        $past(resetn) && !$past(execNonDma) |-> !statusByte[ST_NONDMA])
        else $error("non-DMA bit set outside execution");

    chk_busy_seek: assert property (@(posedge clock) disable iff (!resetn)
        $past(resetn) |-> statusByte[ST_BUSY:ST_SEEK_LO] == $past({cmdBusy, driveSeeking}))
        else $error("busy or seek bits wrong");

    chk_rate_load: assert property (@(posedge clock) disable iff (!resetn)
        rateWriteSeq |=> rateSel == $past(wrData[SEL_HI:SEL_LO]) && compSel == $past(wrData[COMP_HI:COMP_LO]))
        else $error("rate register fields not loaded");

    chk_power_down: assert property (@(posedge clock) disable iff (!resetn)
        rateWrite |=> powerDown == $past(wrData[RATE_PWRDN_BIT]))
        else $error("power-down bit not loaded");

    chk_swreset_pulse: assert property (@(posedge clock) disable iff (!resetn)
        swStart |=> swPulseSeq)
        else $error("software reset pulse too short");

    chk_bresp_after: assert property (@(posedge clock) disable iff (!resetn)
        wrDo |=> bvalid && bresp == ($past(wrMapped) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response missing or wrong");

endmodule
`default_nettype wire

/* src/precomp_delay.sv */
// Write precompensation delay lookup for the effective rate.
`timescale 1ns/1ps
`default_nettype none
module precomp_delay
    import fdc_rate_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [2:0] compSel,
    input var rate_t rateCode,
    output delay_ps_t delayPs
);

    delay_ps_t defaultDelay; // Default for the current rate
    delay_ps_t tableDelay; // Delay from the step tables

    // Default delay depends on rate only
    assign defaultDelay = (rateCode == RATE_2M) ? DELAY_21NS :
                          (rateCode == RATE_1M) ? DELAY_41NS : DELAY_125NS;
    // Tape rate uses the halved step table
    assign tableDelay = (rateCode == RATE_2M) ? COMP_TAPE_PS[compSel] : COMP_DISK_PS[compSel];

    // Registered delay output
    always_ff @(posedge clock) begin
        if (!resetn) begin
            delayPs <= DELAY_125NS;
        end else if (compSel == COMP_DEFAULT) begin
            delayPs <= defaultDelay;
        end else begin
            delayPs <= tableDelay;
        end
    end

    chk_comp_default: assert property (@(posedge clock) disable iff (!resetn)
        compSel == COMP_DEFAULT && rateCode == RATE_1M |=> delayPs == DELAY_41NS)
        else $error("default delay wrong at 1 MB/s");

    chk_comp_steps: assert property (@(posedge clock) disable iff (!resetn)
        compSel == 3'h6 && rateCode != RATE_2M |=> delayPs == 18'h3D090)
        else $error("top precompensation step wrong");

    chk_comp_off: assert property (@(posedge clock) disable iff (!resetn)
        compSel == 3'h7 |=> delayPs == DELAY_OFF)
        else $error("precompensation not disabled");

endmodule
`default_nettype wire

/* src/rate_select.sv */
// Effective data rate and reduced write current selection.
`timescale 1ns/1ps
`default_nettype none
module rate_select
    import fdc_rate_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] rateSel,
    input wire logic [1:0] altRate,
    input wire logic rateWrite,
    input wire logic altWrite,
    input wire logic pcMode,
    input wire logic [1:0] tapeCfg,
    output var rate_t rateCode,
    output logic lowWriteCurrentN
);

    logic lastAlt; // Alternate register written most recently
    logic [1:0] effSel; // Selection in force
    logic tapeRate; // Tape rate combination programmed

    // PC modes always use the alternate source
    assign effSel = (pcMode || lastAlt) ? altRate : rateSel;
    assign tapeRate = (effSel == SEL_300) && (tapeCfg == TAPE_CFG_2M);

    // Track which source was written last
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lastAlt <= 1'b0;
        end else if (altWrite) begin
            lastAlt <= 1'b1;
        end else if (rateWrite) begin
            lastAlt <= 1'b0;
        end
    end

    // Registered rate code and write current level
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rateCode <= RATE_250;
            lowWriteCurrentN <= 1'b0;
        end else begin
            rateCode <= tapeRate ? RATE_2M : rate_t'({1'b0, effSel});
            lowWriteCurrentN <= (effSel == SEL_500) || (effSel == SEL_1M);
        end
    end

    chk_rwc_follow: assert property (@(posedge clock) disable iff (!resetn)
        $past(resetn) |-> lowWriteCurrentN == $past((effSel == SEL_500) || (effSel == SEL_1M)))
        else $error("write current level does not follow rate selection");

    chk_tape_rate: assert property (@(posedge clock) disable iff (!resetn)
        rateCode == RATE_2M |-> $past(effSel == SEL_300 && tapeCfg == TAPE_CFG_2M))
        else $error("tape rate without both fields programmed");

    chk_alt_governs: assert property (@(posedge clock) disable iff (!resetn)
        altWrite ##1 !rateWrite |=> rateCode == $past(tapeRate ? RATE_2M : rate_t'({1'b0, altRate})))
        else $error("alternate rate write did not take effect");

endmodule
`default_nettype wire

/* verif/fdc_core_model.sv */
// Behavioural controller core that feeds the status inputs.
`timescale 1ns/1ps
`default_nettype none
module fdc_core_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] coreState,
    output logic dataRegReady,
    output logic toHost,
    output logic execNonDma,
    output logic cmdBusy,
    output logic [3:0] driveSeeking
);
    // Core flags come from flops, idle after reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            {dataRegReady, toHost, execNonDma, cmdBusy, driveSeeking} <= 8'h00;
        end else begin
            {dataRegReady, toHost, execNonDma, cmdBusy, driveSeeking} <= coreState;
        end
    end
endmodule
`default_nettype wire

/* verif/floppy_status_and_rate_regs_bench.sv */
// Self-checking bench for the floppy status and rate registers.
`timescale 1ns/1ps
`default_nettype none
module floppy_status_and_rate_regs_bench;
    import fdc_rate_pkg::*;
    logic clock = 0, resetn = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [STRB_W-1:0] wstrb = '1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, softReset, powerDown, lowWriteCurrentN;
    logic [1:0] bresp, rresp;
    logic dataRegReady, toHost, execNonDma, cmdBusy;
    logic [3:0] driveSeeking;
    logic [7:0] coreState = '0;
    rate_t rateCode;
    delay_ps_t writeCompPs;
    int n_mismatch = 0, samples_checked = 0;
    // 250 MHz clock
    always #2 clock = ~clock;
    fdc_status_rate_regs i_fdc_status_rate_regs (.*);
    fdc_core_model i_fdc_core_model (.*);
    // Compare one value
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Closing report
    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hung handshake short
    task automatic bound(input int n);
        if (n > 60) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    // Write: readies sampled at the quiet negedge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int n;
        n = 0;
        tb = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!tb) begin
            @(negedge clock);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            n++;
            bound(n);
        end
        bready <= 1'h0;
        chk(r, er);
    endtask
    // Read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        tr = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!tr) begin
            @(negedge clock);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ta) arvalid <= 1'h0;
            n++;
            bound(n);
        end
        rready <= 1'h0;
        chk(d, ed);
        chk(r, er);
    endtask
    // Rate write, then its visible effects
    task automatic rate(input logic [7:0] v, input rate_t er, input delay_ps_t ed);
        wr(ADDR_STATUS_RATE, {24'h0, v}, RESP_OKAY);
        #1 chk(softReset, v[7]);
        repeat (3) @(posedge clock);
        #1 chk(rateCode, er);
        chk(lowWriteCurrentN, er == RATE_500 || er == RATE_1M);
        chk(writeCompPs, ed);
        chk(powerDown, v[6]);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        #1 chk(rateCode, RATE_250);
        chk(writeCompPs, DELAY_125NS);
        rd(ADDR_STATUS_RATE, 32'h0, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            coreState <= 8'h1 << i;
            repeat (3) @(posedge clock);
            rd(ADDR_STATUS_RATE, 32'h1 << i, RESP_OKAY);
        end
        for (int s = 0; s < 4; s++) begin
            rate(8'(s), rate_t'(s), s == 3 ? DELAY_41NS : DELAY_125NS);
        end
        rate(8'h3A, RATE_250, 18'h3D090);
        rate(8'h5E, RATE_250, 18'h00000);
        // Mid-run reset restores the rate register defaults
        @(posedge clock);
        resetn <= 1'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        #1 chk(powerDown, 1'h0);
        chk(writeCompPs, DELAY_125NS);
        chk(rateCode, RATE_250);
        // Write without the low byte lane leaves the rate untouched
        @(posedge clock);
        wstrb <= 4'hE;
        wr(ADDR_STATUS_RATE, 32'h43, RESP_OKAY);
        wstrb <= 4'hF;
        #1 chk(powerDown, 1'h0);
        rate(8'h86, RATE_250, 18'h0A2C6);
        wr(ADDR_CONFIG, 32'h2, RESP_OKAY);
        rate(8'h01, RATE_2M, DELAY_21NS);
        rate(8'h05, RATE_2M, 18'h05140);
        wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
        wr(ADDR_ALT_RATE, 32'h3, RESP_OKAY);
        repeat (3) @(posedge clock);
        #1 chk(rateCode, RATE_1M);
        rd(ADDR_ALT_RATE, 32'h3, RESP_OKAY);
        // PC mode keeps the alternate source after a rate write
        wr(ADDR_CONFIG, 32'h4, RESP_OKAY);
        rate(8'h00, RATE_1M, DELAY_41NS);
        wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
        rate(8'h02, RATE_250, DELAY_125NS);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h0, RESP_SLVERR);
        print_verdict();
    end
endmodule
`default_nettype wire
